// ### src/irq_consts.svh
`ifndef IRQ_CONSTS_SVH
`define IRQ_CONSTS_SVH
// register block window; the vector register lands at 0xFFFFF100
`define BLK_BASE     32'hFFFFF000
`define BLK_SPAN_HI  9
`define SMR_GROUP    2'h0
`define SVR_GROUP    2'h1
`define OFF_IVR      9'h100
`define OFF_FVR      9'h104
`define OFF_ISR      9'h108
`define OFF_IPR      9'h10C
`define OFF_IMR      9'h110
`define OFF_IECR     9'h120
`define OFF_IDCR     9'h124
`define OFF_EOICR    9'h130
// mode register fields
`define SMR_PRIO_HI  2
`define SMR_PRIO_LO  0
`define SMR_TRIG_HI  6
`define SMR_TRIG_LO  5
`define SMR_WR_MASK  8'h67
`define SMR_RST      8'h00
`define SVR_RST      32'h00000000
`define SPURIOUS_VEC 32'h00000000
`define STACK_DEPTH  4'h8
`define NUM_SRC      32
`endif

// ### src/irq_pkg.sv
package irq_pkg;
    typedef logic [31:0] word_t;
    typedef logic [2:0]  prio_t;
    typedef logic [4:0]  src_t;
    // encoding follows declaration order; bit 0 set means edge mode
    typedef enum logic [1:0] {TRIG_HIGH, TRIG_RISE, TRIG_LOW, TRIG_FALL} trig_e;
endpackage

// ### src/vectored_irq_controller.sv
// Overview of operation
// - each source 1..31 holds a handler address returned by a vector read
// - vector register answers at absolute address 0xFFFFF100
// - vector read makes highest enabled pending source current, its priority current level
// - vector read drops the normal request line
// - vector read clears an edge-mode current source; level sources untouched
// - vector read pushes current level and source number onto the stack
// - request line reasserts for a source strictly above the current level
// - end-of-service write pops the stack, restoring the previous level
// - after the pop, sources above the restored level reassert the request
// - only source 0 drives the fast request line
// - source 0 priority field unused but reads back as written
// - source 0 trigger field picks rising, falling, high or low
// - bit 0 written to enable or disable command sets or clears fast enable
// - mask status bit 0 shows the fast enable
// - normal sources carry a three-bit priority, 7 most urgent
// - equal priority ties go to the lowest source number
// - nesting stack is eight entries deep
// - request line asserts only for a priority above the current level
`timescale 1ns/1ps
`include "irq_consts.svh"
module vectored_irq_controller (
    input  wire logic           core_clk,
    input  wire logic           rst_b,
    input  wire irq_pkg::word_t reg_addr,
    input  wire irq_pkg::word_t reg_wdata,
    input  wire logic           reg_wr,
    input  wire logic           reg_rd,
    output irq_pkg::word_t      reg_rdata,
    input  wire logic [31:0]    src_in,
    output logic                normal_request_line_n,
    output logic                fast_request_line_n
);
    import irq_pkg::*;

    logic [7:0]  smr_q [`NUM_SRC];
    word_t       svr_q [`NUM_SRC];
    logic [31:0] s1_q, s2_q, s3_q, filt_q, prev_q, edge_q, imr_q;
    prio_t       stk_prio_q [8];
    src_t        stk_src_q [8];
    logic [3:0]  sp_q;
    word_t       rdata_q;
    logic [31:0] agree, ev, lvl, pend, elig, clr_edge;
    logic        in_blk, ivr_rd, fvr_rd, eoi_wr, found;
    logic [8:0]  off;
    logic [2:0]  top_idx;
    prio_t       cur_lvl, best_prio;
    src_t        best;
    word_t       best_vec;

    function automatic prio_t prio_of(input logic [7:0] m);
        return m[`SMR_PRIO_HI:`SMR_PRIO_LO];
    endfunction

    function automatic logic is_edge(input logic [7:0] m);
        return m[`SMR_TRIG_LO]; // rise and fall codes are odd
    endfunction

    // address decode; the block window sits at a fixed absolute base
    assign in_blk = (reg_addr[31:`BLK_SPAN_HI] == 23'(`BLK_BASE >> `BLK_SPAN_HI));
    assign off    = reg_addr[8:0];
    assign ivr_rd = reg_rd && in_blk && off == `OFF_IVR;
    assign fvr_rd = reg_rd && in_blk && off == `OFF_FVR;
    assign eoi_wr = reg_wr && in_blk && off == `OFF_EOICR;

    // pin inputs: three stages, a change counts once stages two and three agree
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_q   <= 32'h00000000;
            s2_q   <= 32'h00000000;
            s3_q   <= 32'h00000000;
            filt_q <= 32'h00000000;
            prev_q <= 32'h00000000;
        end else begin
            s1_q   <= src_in;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            filt_q <= (s3_q & agree) | (filt_q & ~agree);
            prev_q <= filt_q;
        end
    end
    assign agree = ~(s2_q ^ s3_q);

    // condition per source from its trigger field
    always_comb begin
        for (int i = 0; i < `NUM_SRC; i++) begin
            case (trig_e'(smr_q[i][`SMR_TRIG_HI:`SMR_TRIG_LO]))
                TRIG_HIGH: begin
                    lvl[i] = filt_q[i];
                    ev[i]  = 1'b0;
                end
                TRIG_LOW: begin
                    lvl[i] = ~filt_q[i];
                    ev[i]  = 1'b0;
                end
                TRIG_RISE: begin
                    lvl[i] = 1'b0;
                    ev[i]  = filt_q[i] & ~prev_q[i];
                end
                TRIG_FALL: begin
                    lvl[i] = 1'b0;
                    ev[i]  = ~filt_q[i] & prev_q[i];
                end
                default: begin
                    lvl[i] = 1'b0;
                    ev[i]  = 1'b0;
                end
            endcase
            pend[i] = is_edge(smr_q[i]) ? edge_q[i] : lvl[i];
        end
    end

    // current level is the stack top; an empty stack admits every priority
    assign top_idx = 3'(sp_q - 4'h1);
    assign cur_lvl = stk_prio_q[top_idx];

    // eligibility and arbitration over normal sources only
    always_comb begin
        elig[0]   = 1'b0;
        found     = 1'b0;
        best      = 5'h00;
        best_prio = 3'h0;
        for (int i = 1; i < `NUM_SRC; i++) begin
            elig[i] = pend[i] && imr_q[i]
                      && (sp_q == 4'h0 || prio_of(smr_q[i]) > cur_lvl);
            // strict compare keeps the lowest number on a tie
            if (elig[i] && (!found || prio_of(smr_q[i]) > best_prio)) begin
                found     = 1'b1;
                best      = 5'(i);
                best_prio = prio_of(smr_q[i]);
            end
        end
    end
    assign best_vec = svr_q[best];

    // request lines decode registered state only, so they cannot glitch on bus strobes
    assign normal_request_line_n = ~|elig;
    assign fast_request_line_n   = ~(pend[0] & imr_q[0]);

    // clear strobes for the edge latches, raised by the two vector reads
    always_comb begin
        clr_edge = 32'h00000000;
        if (ivr_rd && found && is_edge(smr_q[best])) begin
            clr_edge[best] = 1'b1;
        end
        if (fvr_rd) begin
            clr_edge[0] = 1'b1;
        end
    end

    // edge latches: a new edge in the clearing cycle wins over the clear
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            edge_q <= 32'h00000000;
        end else begin
            edge_q <= (edge_q & ~clr_edge) | ev;
        end
    end

    // enable mask set and cleared by command writes
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            imr_q <= 32'h00000000;
        end else if (reg_wr && in_blk && off == `OFF_IECR) begin
            imr_q <= imr_q | reg_wdata;
        end else if (reg_wr && in_blk && off == `OFF_IDCR) begin
            imr_q <= imr_q & ~reg_wdata;
        end
    end

    // mode and handler address registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < `NUM_SRC; i++) begin
                smr_q[i] <= `SMR_RST;
                svr_q[i] <= `SVR_RST;
            end
        end else if (reg_wr && in_blk && off[8:7] == `SMR_GROUP) begin
            smr_q[off[6:2]] <= reg_wdata[7:0] & `SMR_WR_MASK;
        end else if (reg_wr && in_blk && off[8:7] == `SVR_GROUP) begin
            svr_q[off[6:2]] <= reg_wdata;
        end
    end

    // nesting stack; a push only happens above the current level, so eight suffice
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sp_q <= 4'h0;
            for (int i = 0; i < 8; i++) begin
                stk_prio_q[i] <= 3'h0;
                stk_src_q[i]  <= 5'h00;
            end
        end else if (ivr_rd && found && sp_q < `STACK_DEPTH) begin
            stk_prio_q[sp_q[2:0]] <= best_prio;
            stk_src_q[sp_q[2:0]]  <= best;
            sp_q                  <= sp_q + 4'h1;
        end else if (eoi_wr && sp_q != 4'h0) begin
            sp_q <= sp_q - 4'h1;
        end
    end

    // read data stands in the cycle after the strobe only
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= 32'h00000000;
        end else if (reg_rd && in_blk) begin
            if (off == `OFF_IVR) begin
                rdata_q <= found ? best_vec : `SPURIOUS_VEC;
            end else if (off == `OFF_FVR) begin
                rdata_q <= svr_q[0];
            end else if (off == `OFF_ISR) begin
                rdata_q <= (sp_q == 4'h0) ? 32'h00000000 : {27'h0, stk_src_q[top_idx]};
            end else if (off == `OFF_IPR) begin
                rdata_q <= pend;
            end else if (off == `OFF_IMR) begin
                rdata_q <= imr_q;
            end else if (off[8:7] == `SMR_GROUP) begin
                rdata_q <= {24'h0, smr_q[off[6:2]]};
            end else if (off[8:7] == `SVR_GROUP) begin
                rdata_q <= svr_q[off[6:2]];
            end else begin
                rdata_q <= 32'h00000000;
            end
        end else begin
            rdata_q <= 32'h00000000;
        end
    end
    assign reg_rdata = rdata_q;

    // checks on the vector read, the stack and the mask commands
    a_vector_returned: assert property (@(posedge core_clk) disable iff (!rst_b)
        ivr_rd && found |=> reg_rdata == $past(best_vec))
        else $error("vector read returned wrong handler address");
    a_ivr_push_level: assert property (@(posedge core_clk) disable iff (!rst_b)
        ivr_rd && found && sp_q < 4'h8 |=> sp_q == $past(sp_q) + 4'h1
            && cur_lvl == $past(best_prio))
        else $error("vector read did not push the current level");
    a_edge_autoclear: assert property (@(posedge core_clk) disable iff (!rst_b)
        ivr_rd && found && is_edge(smr_q[best]) && !ev[best] |=> !edge_q[$past(best)])
        else $error("edge source not cleared by vector read");
    a_eoi_pop_stack: assert property (@(posedge core_clk) disable iff (!rst_b)
        eoi_wr && sp_q != 4'h0 |=> sp_q == $past(sp_q) - 4'h1)
        else $error("end of service did not pop the stack");
    a_irq_above_level: assert property (@(posedge core_clk) disable iff (!rst_b)
        !normal_request_line_n && sp_q != 4'h0 |-> best_prio > cur_lvl)
        else $error("request asserted at or below current level");
    a_fast_enable_cmd: assert property (@(posedge core_clk) disable iff (!rst_b)
        reg_wr && in_blk && off == `OFF_IECR && reg_wdata[0] |=> imr_q[0])
        else $error("fast enable command ignored");
    a_fast_disable_cmd: assert property (@(posedge core_clk) disable iff (!rst_b)
        reg_wr && in_blk && off == `OFF_IDCR && reg_wdata[0] |=> !imr_q[0] && fast_request_line_n)
        else $error("fast disable command ignored");
    a_mask_readback: assert property (@(posedge core_clk) disable iff (!rst_b)
        reg_rd && in_blk && off == `OFF_IMR |=> reg_rdata[0] == $past(imr_q[0]))
        else $error("mask status bit 0 wrong");

    // normal path: after a push only a strictly higher source may request again
    a_ivr_drops_line: assert property (@(posedge core_clk) disable iff (!rst_b)
        ivr_rd && found && sp_q < 4'h8 |=> normal_request_line_n || best_prio > $past(best_prio))
        else $error("request line not dropped by vector read");
    a_edge_new_wins: assert property (@(posedge core_clk) disable iff (!rst_b)
        ivr_rd && found && is_edge(smr_q[best]) && ev[best] |=> edge_q[$past(best)])
        else $error("new edge lost in clearing cycle");
    a_level_kept: assert property (@(posedge core_clk) disable iff (!rst_b)
        ivr_rd && found && !is_edge(smr_q[best]) |=> edge_q == ($past(edge_q) | $past(ev)))
        else $error("vector read touched a level source");
    a_spurious_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
        ivr_rd && !found |=> reg_rdata == `SPURIOUS_VEC && sp_q == $past(sp_q))
        else $error("spurious vector read changed state");
    a_empty_admits_all: assert property (@(posedge core_clk) disable iff (!rst_b)
        sp_q == 4'h0 && (pend[31:1] & imr_q[31:1]) != 31'h00000000 |-> !normal_request_line_n)
        else $error("idle controller ignored a pending source");
    a_stack_bound: assert property (@(posedge core_clk) disable iff (!rst_b)
        sp_q <= `STACK_DEPTH)
        else $error("stack pointer beyond eight entries");
    a_eoi_empty_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
        eoi_wr && sp_q == 4'h0 |=> sp_q == 4'h0)
        else $error("end of service on empty stack moved pointer");
    a_src0_not_normal: assert property (@(posedge core_clk) disable iff (!rst_b)
        ivr_rd && found |-> best != 5'h00)
        else $error("source 0 chosen as normal interrupt");
    a_rdata_idle: assert property (@(posedge core_clk) disable iff (!rst_b)
        !reg_rd |=> reg_rdata == 32'h00000000)
        else $error("read data outside the answer cycle");

    // fast path: source 0 only, no arbitration, trigger field decides
    a_fast_needs_src0: assert property (@(posedge core_clk) disable iff (!rst_b)
        !fast_request_line_n |-> pend[0] && imr_q[0])
        else $error("fast request without enabled source 0");
    a_fast_no_prio: assert property (@(posedge core_clk) disable iff (!rst_b)
        $changed(sp_q) && $stable(pend[0]) && $stable(imr_q[0]) |-> $stable(fast_request_line_n))
        else $error("fast request moved with the stack");
    a_smr0_readback: assert property (@(posedge core_clk) disable iff (!rst_b)
        reg_wr && in_blk && off[8:7] == `SMR_GROUP && off[6:2] == 5'h00
        |=> smr_q[0] == ($past(reg_wdata[7:0]) & `SMR_WR_MASK))
        else $error("source 0 mode register not stored");
    a_fast_high_level: assert property (@(posedge core_clk) disable iff (!rst_b)
        smr_q[0][`SMR_TRIG_HI:`SMR_TRIG_LO] == TRIG_HIGH && imr_q[0]
        |-> fast_request_line_n == !filt_q[0])
        else $error("fast high level mode wrong");
    a_fast_low_level: assert property (@(posedge core_clk) disable iff (!rst_b)
        smr_q[0][`SMR_TRIG_HI:`SMR_TRIG_LO] == TRIG_LOW && imr_q[0]
        |-> fast_request_line_n == filt_q[0])
        else $error("fast low level mode wrong");
    a_fvr_autoclear: assert property (@(posedge core_clk) disable iff (!rst_b)
        fvr_rd && is_edge(smr_q[0]) && !ev[0] |=> !edge_q[0])
        else $error("fast vector read did not clear source 0");
endmodule

// ### bench/core_model.sv
`timescale 1ns/1ps
// processor core side: takes a normal request only while its own mask is clear; the fast request ignores the mask
module core_model (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic irq_mask,
    input  wire logic normal_request_line_n,
    input  wire logic fast_request_line_n,
    output logic      take_irq,
    output logic      take_fiq
);
    // masking hides a reassertion during the exit sequence
    assign take_irq = rst_b & ~irq_mask & ~normal_request_line_n;
    assign take_fiq = rst_b & ~fast_request_line_n;
endmodule

// ### bench/testbench.sv
`timescale 1ns/1ps
`include "irq_consts.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module testbench;
    import irq_pkg::*;
    logic        core_clk, rst_b, reg_wr, reg_rd, irq_mask, rq_n, fq_n, take_irq;
    word_t       reg_addr, reg_wdata, reg_rdata, rv, p;
    logic [31:0] src_in, seed;
    word_t       sv [32];
    int          n_errors, comparisons, cyc, a, b, m;
    localparam word_t B = `BLK_BASE;

    vectored_irq_controller u_vectored_irq_controller (
        .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_in(src_in),
        .normal_request_line_n(rq_n), .fast_request_line_n(fq_n));
    core_model u_core_model (
        .core_clk(core_clk), .rst_b(rst_b), .irq_mask(irq_mask),
        .normal_request_line_n(rq_n), .fast_request_line_n(fq_n),
        .take_irq(take_irq), .take_fiq());

    // xorshift keeps the run repeatable
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic wr(input word_t ad, input word_t d);
        @(posedge core_clk);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // data stands only in the cycle after the strobe
    task automatic rd(input word_t ad, output word_t d);
        @(posedge core_clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // pins pass a synchroniser, so give them eight cycles to land
    task automatic setsrc(input int i, input logic v);
        @(posedge core_clk);
        src_in[i] <= v;
        repeat (8) @(posedge core_clk);
        #1;
    endtask

    task automatic wrap_up();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // hang guard, far above the few hundred cycles the sequence needs
    always @(posedge core_clk) begin
        cyc++;
        if (cyc > 20000) begin
            n_errors++;
            wrap_up();
        end
    end

    initial begin
        {rst_b, reg_wr, reg_rd, irq_mask} = 4'h0;
        reg_addr = 32'h0;
        reg_wdata = 32'h0;
        src_in = 32'h0;
        seed = 30123;
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        rd(B + `OFF_IMR, rv); `CHK(rv, 32'h0)
        wr(B + `OFF_IECR, 32'h1); rd(B + `OFF_IMR, rv); `CHK(rv, 32'h1)
        wr(B + `OFF_IDCR, 32'h1); rd(B + `OFF_IMR, rv); `CHK(rv, 32'h0)
        wr(B + `OFF_IECR, 32'h1);
        p = rnd();
        wr(B, p); rd(B, rv); `CHK(rv, p & 32'h67)
        // all four fast modes; edge modes latch until the fast vector read
        for (m = 0; m < 4; m++) begin
            wr(B, (m << 5) | (p & 32'h7));
            setsrc(0, m[1]); rd(B + `OFF_FVR, rv); `CHK(fq_n, 1'b1)
            setsrc(0, ~m[1]); `CHK(fq_n, 1'b0)
            setsrc(0, m[1]); `CHK(fq_n, ~m[0])
            rd(B + `OFF_FVR, rv); `CHK(fq_n, 1'b1)
            `CHK(rq_n, 1'b1)
        end
        a = 1 + rnd() % 15;
        b = 16 + rnd() % 15;
        foreach (sv[i]) begin
            sv[i] = rnd();
            wr(B + 32'h80 + 4 * i, sv[i]);
        end
        wr(B + 4 * a, 32'h3);
        wr(B + 4 * b, 32'h3);
        wr(B + 4 * 31, 32'h25);
        wr(B + `OFF_IECR, (32'h1 << a) | (32'h1 << b) | 32'h80000000);
        setsrc(b, 1'b1); setsrc(a, 1'b1); `CHK(rq_n, 1'b0)
        rd(B + `OFF_IVR, rv); `CHK(rv, sv[a])
        `CHK(rq_n, 1'b1)
        setsrc(31, 1'b1); `CHK(take_irq, 1'b1)
        rd(B + `OFF_IVR, rv); `CHK(rv, sv[31])
        `CHK(rq_n, 1'b1)
        rd(B + `OFF_ISR, rv); `CHK(rv, 32'd31)
        rd(B + `OFF_IPR, rv); `CHK(rv[31], 1'b0)
        `CHK(rv[a], 1'b1)
        irq_mask <= 1'b1;
        wr(B + `OFF_EOICR, 32'h0); `CHK(rq_n, 1'b1)
        rd(B + `OFF_ISR, rv); `CHK(rv, a)
        setsrc(a, 1'b0);
        wr(B + `OFF_EOICR, 32'h0); `CHK(rq_n, 1'b0)
        `CHK(take_irq, 1'b0)
        @(posedge core_clk) irq_mask <= 1'b0;
        #1 `CHK(take_irq, 1'b1)
        rd(B + `OFF_IVR, rv); `CHK(rv, sv[b])
        rd(B + 32'h1FC, rv); `CHK(rv, 32'h0)
        rd(32'h0000F100, rv); `CHK(rv, 32'h0)
        wrap_up();
    end
endmodule
